// file: hdl/cvc_regs.vh
// constants for the vertical timing, cursor and addressing block
// assumes an indexed register pair and one clock per character
`ifndef CVC_REGS_VH
`define CVC_REGS_VH
// register indexes
`define CVC_IDX_VTOTAL    6'h06
`define CVC_IDX_OVFL      6'h07
`define CVC_IDX_PRESET    6'h08
`define CVC_IDX_MAXSCAN   6'h09
`define CVC_IDX_CUR_START 6'h0a
`define CVC_IDX_CUR_END   6'h0b
`define CVC_IDX_START_HI  6'h0c
`define CVC_IDX_START_LO  6'h0d
`define CVC_IDX_CUR_HI    6'h0e
`define CVC_IDX_CUR_LO    6'h0f
`define CVC_IDX_VSS       6'h10
`define CVC_IDX_VSE       6'h11
`define CVC_IDX_VDE       6'h12
`define CVC_IDX_OFFSET    6'h13
`define CVC_IDX_UNDERLINE 6'h14
`define CVC_IDX_VBS       6'h15
`define CVC_IDX_VBE       6'h16
// overflow register fields
`define CVC_OV_VT8  0
`define CVC_OV_VDE8 1
`define CVC_OV_VSS8 2
`define CVC_OV_VBS8 3
`define CVC_OV_LC8  4
`define CVC_OV_VT9  5
`define CVC_OV_VDE9 6
`define CVC_OV_VSS9 7
// max scan line fields
`define CVC_MS_VBS9 5
`define CVC_MS_LC9  6
`define CVC_MS_DBL  7
// cursor fields
`define CVC_CS_OFF  5
// sync end register fields
`define CVC_SE_ICLR 4
`define CVC_SE_IEN  5
`define CVC_SE_REF  6
`define CVC_SE_PROT 7
// underline register fields
`define CVC_UL_CBY4 5
`define CVC_UL_DWRD 6
// common field ranges
`define CVC_ROW_MSB 4
`define CVC_PAN_MSB 6
`define CVC_PAN_LSB 5
`define CVC_SKW_MSB 6
`define CVC_SKW_LSB 5
// reset values
`define CVC_REG_RST  8'h00
`define CVC_LINE_RST 10'h000
// refresh cycles per line
`define CVC_REF_SLOW 3'h3
`define CVC_REF_FAST 3'h5
// legacy emulation codes and address masks
`define CVC_EMU_NONE 2'h0
`define CVC_EMU_16K  2'h1
`define CVC_EMU_32K  2'h2
`define CVC_EMU_64K  2'h3
`define CVC_MASK_16K 16'h3fff
`define CVC_MASK_32K 16'h7fff
`define CVC_MASK_64K 16'hffff
// address steps
`define CVC_STEP_1 16'h0001
`define CVC_STEP_2 16'h0002
`define CVC_STEP_4 16'h0004
`endif

// file: hdl/cvc_vert.v
// vertical timing, row scan, text cursor and display addressing
// assumes sys_clk is the character clock, line_tick one pulse per
// horizontal retrace, h_disp high during active characters of a line
`timescale 1ns/1ps
`default_nettype none
`include "cvc_regs.vh"
//
// Overview of operation
// - vertical total is lines per frame minus two
// - overflow and max-scan supply high timing bits
// - row scan loads preset, counts lines, clears
// - byte panning adds low start address bits
// - scan lines per row is field plus one
// - double scan slows row scan and addressing only
// - cursor starts at start line; off bit hides
// - cursor ends at end plus one; skew delays
// - start above end means no cursor
// - 16-bit start and cursor addresses, two bytes
// - legacy modes wrap addresses at 16/32/64K
// - pen readback loads at line compare, gated read
// - 10-bit sync start; gated readability
// - sync ends on low four bits match
// - clear bit zero clears irq; enable zero enables
// - refresh type picks three or five cycles
// - group0 protect blocks total group writes
// - displayed lines equal display end plus one
// - next row start adds K times offset
// - underline on field plus one
// - count by four and doubleword addressing
// - blank begins at start, ends low-8 match
// - pen enable low exposes pen readback
module cvc_vert (
   input  wire        sys_clk,       // character clock
   input  wire        reset,         // synchronous, active high
   input  wire        idx_wr,        // write strobe to index register
   input  wire        data_wr,       // write strobe to data register
   input  wire [7:0]  io_wdata,      // write data
   input  wire        line_tick,     // one pulse per horizontal retrace
   input  wire        h_disp,        // horizontal active display
   input  wire        pen_enable,    // light pen enable from hblank end reg
   input  wire        mono_emul,     // legacy monochrome emulation
   input  wire [1:0]  emul_mode,     // legacy wrap mode select
   input  wire        ext_protect,   // extension protect bit
   input  wire        aux_offset,    // finer offset bit
   input  wire        word_mode_n,   // crt mode ctrl: 1 byte, 0 word
   input  wire        count_by_two,  // crt mode ctrl count by two
   input  wire [7:0]  line_cmp_low,  // low bits of line compare
   output reg  [7:0]  io_rdata_q,    // data register read value
   output reg         vsync_q,       // vertical sync
   output reg         vblank_q,      // vertical blank
   output reg         vdisp_q,       // vertical display enable
   output reg         irq_q,         // vertical interrupt pending
   output reg  [4:0]  row_scan_q,    // row scan counter
   output reg  [15:0] mem_addr_q,    // display memory address
   output reg         cursor_q,      // text cursor after skew
   output reg         underline_q,   // underline scan line
   output reg  [2:0]  refresh_q,     // refresh cycles per line
   output reg         g0_protect_q   // group0 protection active
);

   // register storage
   reg [5:0]  index_q;         // data register index
   reg [7:0]  vt_q;            // vertical_total_low
   reg [7:0]  ovfl_q;          // vertical_overflow_bits
   reg [7:0]  preset_q;        // preset_row_scan
   reg [7:0]  maxscan_q;       // max_scan_line
   reg [7:0]  cstart_q;        // cursor_start_line
   reg [7:0]  cend_q;          // cursor_end_line
   reg [7:0]  start_hi_q;      // display_start_high
   reg [7:0]  start_lo_q;      // display_start_low
   reg [7:0]  cur_hi_q;        // cursor_location_high
   reg [7:0]  cur_lo_q;        // cursor_location_low
   reg [7:0]  vss_q;           // vertical_sync_start
   reg [7:0]  vse_q;           // vertical_sync_end_ctrl
   reg [7:0]  vde_q;           // vertical_display_end
   reg [7:0]  offset_q;        // row_offset
   reg [7:0]  ul_q;            // underline_location
   reg [7:0]  vbs_q;           // vertical_blank_start
   reg [7:0]  vbe_q;           // vertical_blank_end
   reg [7:0]  pen_hi_q;        // pen_readback_high
   reg [7:0]  pen_lo_q;        // pen_readback_low
   // counters and pipeline
   reg [9:0]  line_q;          // scan line counter
   reg        dbl_phase_q;     // second line of a doubled pair
   reg [15:0] row_start_q;     // start address of current row
   reg [3:0]  cur_pipe_q;      // cursor skew pipeline

   // address wrap for legacy emulation modes
   function [15:0] wrap;
      input [15:0] a;
      input [1:0]  m;
      begin
         case (m)
            `CVC_EMU_16K: wrap = a & `CVC_MASK_16K;
            `CVC_EMU_32K: wrap = a & `CVC_MASK_32K;
            `CVC_EMU_64K: wrap = a & `CVC_MASK_64K;
            default:      wrap = a;
         endcase
      end
   endfunction

   // assembled 10-bit timing values
   wire [9:0] vtotal = {ovfl_q[`CVC_OV_VT9], ovfl_q[`CVC_OV_VT8], vt_q};
   wire [9:0] vdend  = {ovfl_q[`CVC_OV_VDE9], ovfl_q[`CVC_OV_VDE8], vde_q};
   wire [9:0] vsstart = {ovfl_q[`CVC_OV_VSS9], ovfl_q[`CVC_OV_VSS8], vss_q};
   wire [9:0] vbstart = {maxscan_q[`CVC_MS_VBS9], ovfl_q[`CVC_OV_VBS8], vbs_q};
   wire [9:0] lcmp   = {maxscan_q[`CVC_MS_LC9], ovfl_q[`CVC_OV_LC8], line_cmp_low};

   // line counter events; last line is vtotal + 1
   wire       frame_end = (line_q == (vtotal + 10'h001));
   wire [9:0] line_nx   = frame_end ? `CVC_LINE_RST : line_q + 10'h001;
   wire       lc_hit    = (line_nx == lcmp);

   // row addressing step, K times offset with finer bit
   wire        dword   = ul_q[`CVC_UL_DWRD];
   wire [15:0] half_inc = {7'h00, offset_q, aux_offset};
   wire [15:0] row_inc = dword ? {half_inc[13:0], 2'b00} :
                         (word_mode_n ? half_inc : {half_inc[14:0], 1'b0});
   // character address step
   wire [15:0] ch_step = (ul_q[`CVC_UL_CBY4] && !count_by_two) ? `CVC_STEP_4 :
                         (count_by_two ? `CVC_STEP_2 : `CVC_STEP_1);

   // start address with byte panning in the low bits
   wire [15:0] start_eff = wrap({start_hi_q, start_lo_q} +
                           {14'h0000, preset_q[`CVC_PAN_MSB:`CVC_PAN_LSB]},
                           emul_mode);
   wire [15:0] cur_loc = wrap({cur_hi_q, cur_lo_q}, emul_mode);

   // row scan advance; doubled lines advance every second line
   wire row_adv = !maxscan_q[`CVC_MS_DBL] || dbl_phase_q;
   wire row_last = (row_scan_q == maxscan_q[`CVC_ROW_MSB:0]);

   // cursor scan range
   wire [5:0] cs6 = {1'b0, cstart_q[`CVC_ROW_MSB:0]};
   wire [5:0] ce6 = {1'b0, cend_q[`CVC_ROW_MSB:0]} + 6'h01;
   wire [5:0] rs6 = {1'b0, row_scan_q};
   wire cur_line = !cstart_q[`CVC_CS_OFF] &&
                   (cstart_q[`CVC_ROW_MSB:0] <= cend_q[`CVC_ROW_MSB:0]) &&
                   (rs6 >= cs6) && (rs6 <= ce6);
   wire cur_raw = cur_line && vdisp_q && h_disp && (mem_addr_q == cur_loc);
   wire [1:0] skew = cend_q[`CVC_SKW_MSB:`CVC_SKW_LSB];

   // readback selection for shared pen and sync indexes
   wire pen_view = mono_emul || !pen_enable;
   wire prot = vse_q[`CVC_SE_PROT] || ext_protect;

   // index register
   always @(posedge sys_clk) begin
      if (reset) begin
         index_q <= 6'h00;
      end else if (idx_wr) begin
         index_q <= io_wdata[5:0];
      end
   end

   // data register writes with group0 protection
   always @(posedge sys_clk) begin
      if (reset) begin
         vt_q <= `CVC_REG_RST;
         ovfl_q <= `CVC_REG_RST;
         preset_q <= `CVC_REG_RST;
         maxscan_q <= `CVC_REG_RST;
         cstart_q <= `CVC_REG_RST;
         cend_q <= `CVC_REG_RST;
         start_hi_q <= `CVC_REG_RST;
         start_lo_q <= `CVC_REG_RST;
         cur_hi_q <= `CVC_REG_RST;
         cur_lo_q <= `CVC_REG_RST;
         vss_q <= `CVC_REG_RST;
         vse_q <= `CVC_REG_RST;
         vde_q <= `CVC_REG_RST;
         offset_q <= `CVC_REG_RST;
         ul_q <= `CVC_REG_RST;
         vbs_q <= `CVC_REG_RST;
         vbe_q <= `CVC_REG_RST;
      end else if (data_wr) begin
         case (index_q)
            `CVC_IDX_VTOTAL: begin
               if (!prot)
                  vt_q <= io_wdata;
            end
            `CVC_IDX_OVFL: begin
               // line compare bit 8 stays writable
               if (prot)
                  ovfl_q[`CVC_OV_LC8] <= io_wdata[`CVC_OV_LC8];
               else
                  ovfl_q <= io_wdata;
            end
            `CVC_IDX_PRESET:    preset_q <= {1'b0, io_wdata[6:0]};
            `CVC_IDX_MAXSCAN:   maxscan_q <= io_wdata;
            `CVC_IDX_CUR_START: cstart_q <= {2'b00, io_wdata[5:0]};
            `CVC_IDX_CUR_END:   cend_q <= {1'b0, io_wdata[6:0]};
            `CVC_IDX_START_HI:  start_hi_q <= io_wdata;
            `CVC_IDX_START_LO:  start_lo_q <= io_wdata;
            `CVC_IDX_CUR_HI:    cur_hi_q <= io_wdata;
            `CVC_IDX_CUR_LO:    cur_lo_q <= io_wdata;
            `CVC_IDX_VSS:       vss_q <= io_wdata;
            `CVC_IDX_VSE:       vse_q <= io_wdata;
            `CVC_IDX_VDE:       vde_q <= io_wdata;
            `CVC_IDX_OFFSET:    offset_q <= io_wdata;
            `CVC_IDX_UNDERLINE: ul_q <= {1'b0, io_wdata[6:0]};
            `CVC_IDX_VBS:       vbs_q <= io_wdata;
            `CVC_IDX_VBE:       vbe_q <= io_wdata;
            default: begin
               // unmapped index, write ignored
            end
         endcase
      end
   end

   // read data, registered one cycle behind the index
   always @(posedge sys_clk) begin
      if (reset) begin
         io_rdata_q <= `CVC_REG_RST;
      end else begin
         case (index_q)
            `CVC_IDX_VTOTAL:    io_rdata_q <= vt_q;
            `CVC_IDX_OVFL:      io_rdata_q <= ovfl_q;
            `CVC_IDX_PRESET:    io_rdata_q <= preset_q;
            `CVC_IDX_MAXSCAN:   io_rdata_q <= maxscan_q;
            `CVC_IDX_CUR_START: io_rdata_q <= cstart_q;
            `CVC_IDX_CUR_END:   io_rdata_q <= cend_q;
            `CVC_IDX_START_HI:  io_rdata_q <= start_hi_q;
            `CVC_IDX_START_LO:  io_rdata_q <= start_lo_q;
            `CVC_IDX_CUR_HI:    io_rdata_q <= cur_hi_q;
            `CVC_IDX_CUR_LO:    io_rdata_q <= cur_lo_q;
            `CVC_IDX_VSS:       io_rdata_q <= pen_view ? pen_hi_q : vss_q;
            `CVC_IDX_VSE:       io_rdata_q <= pen_view ? pen_lo_q : vse_q;
            `CVC_IDX_VDE:       io_rdata_q <= vde_q;
            `CVC_IDX_OFFSET:    io_rdata_q <= offset_q;
            `CVC_IDX_UNDERLINE: io_rdata_q <= ul_q;
            `CVC_IDX_VBS:       io_rdata_q <= vbs_q;
            `CVC_IDX_VBE:       io_rdata_q <= vbe_q;
            default:            io_rdata_q <= `CVC_REG_RST;
         endcase
      end
   end

   // scan line counter and vertical windows
   always @(posedge sys_clk) begin
      if (reset) begin
         line_q <= `CVC_LINE_RST;
         vsync_q <= 1'b0;
         vblank_q <= 1'b0;
         vdisp_q <= 1'b1;
      end else if (line_tick) begin
         line_q <= line_nx;
         // display covers lines 0 through display end
         if (frame_end)
            vdisp_q <= 1'b1;
         else if (line_nx == (vdend + 10'h001))
            vdisp_q <= 1'b0;
         // sync start full compare, end on low four bits
         if (line_nx == vsstart)
            vsync_q <= 1'b1;
         else if (line_nx[3:0] == vse_q[3:0])
            vsync_q <= 1'b0;
         // blank from start through the line matching low eight bits
         if (line_nx == vbstart)
            vblank_q <= 1'b1;
         else if (line_q[7:0] == vbe_q)
            vblank_q <= 1'b0;
      end
   end

   // vertical interrupt: sets only while the clear bit is one; clear bit zero clears
   always @(posedge sys_clk) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else if (line_tick && (line_nx == (vdend + 10'h001)) &&
                   !vse_q[`CVC_SE_IEN] && vse_q[`CVC_SE_ICLR]) begin
         irq_q <= 1'b1;
      end else if (!vse_q[`CVC_SE_ICLR]) begin
         irq_q <= 1'b0;
      end
   end

   // row scan counter and row start address
   always @(posedge sys_clk) begin
      if (reset) begin
         row_scan_q <= 5'h00;
         dbl_phase_q <= 1'b0;
         row_start_q <= 16'h0000;
      end else if (line_tick) begin
         if (frame_end) begin
            row_scan_q <= preset_q[`CVC_ROW_MSB:0];
            dbl_phase_q <= 1'b0;
            row_start_q <= start_eff;
         end else if (lc_hit) begin
            // split screen restarts addressing at zero
            row_scan_q <= 5'h00;
            dbl_phase_q <= 1'b0;
            row_start_q <= 16'h0000;
         end else begin
            dbl_phase_q <= maxscan_q[`CVC_MS_DBL] && !dbl_phase_q;
            if (row_adv && vdisp_q) begin
               if (row_last) begin
                  row_scan_q <= 5'h00;
                  row_start_q <= wrap(row_start_q + row_inc, emul_mode);
               end else begin
                  row_scan_q <= row_scan_q + 5'h01;
               end
            end
         end
      end
   end

   // character address across a line
   always @(posedge sys_clk) begin
      if (reset) begin
         mem_addr_q <= 16'h0000;
      end else if (line_tick) begin
         mem_addr_q <= row_start_q;
      end else if (h_disp && vdisp_q) begin
         mem_addr_q <= wrap(mem_addr_q + ch_step, emul_mode);
      end
   end

   // light pen readback loads the address at line compare
   always @(posedge sys_clk) begin
      if (reset) begin
         pen_hi_q <= `CVC_REG_RST;
         pen_lo_q <= `CVC_REG_RST;
      end else if (line_tick && lc_hit) begin
         pen_hi_q <= mem_addr_q[15:8];
         pen_lo_q <= mem_addr_q[7:0];
      end
   end

   // cursor skew pipeline, underline, refresh and protect status
   always @(posedge sys_clk) begin
      if (reset) begin
         cur_pipe_q <= 4'h0;
         cursor_q <= 1'b0;
         underline_q <= 1'b0;
         refresh_q <= `CVC_REF_SLOW;
         g0_protect_q <= 1'b0;
      end else begin
         cur_pipe_q <= {cur_pipe_q[2:0], cur_raw};
         cursor_q <= cur_pipe_q[skew];
         underline_q <= (rs6 == ({1'b0, ul_q[`CVC_ROW_MSB:0]} + 6'h01));
         refresh_q <= vse_q[`CVC_SE_REF] ? `CVC_REF_FAST : `CVC_REF_SLOW;
         g0_protect_q <= prot;
      end
   end

endmodule // cvc_vert
`default_nettype wire

// file: verif/cvc_vert_properties.sv
// concurrent checks on the ports of the vertical timing block
// assumes a bind onto cvc_vert, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module cvc_vert_properties (
   input wire logic       sys_clk,      // character clock
   input wire logic       reset,        // synchronous, active high
   input wire logic       data_wr,      // register write strobe
   input wire logic       line_tick,    // one pulse per line
   input wire logic       ext_protect,  // extension protect bit
   input wire logic       vsync_q,      // vertical sync
   input wire logic       vblank_q,     // vertical blank
   input wire logic       vdisp_q,      // vertical display enable
   input wire logic       irq_q,        // interrupt pending
   input wire logic [4:0] row_scan_q,   // row scan counter
   input wire logic [2:0] refresh_q,    // refresh cycles per line
   input wire logic       g0_protect_q  // group0 protection
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // refresh count only takes its two legal values
   rf_legal_a: assert property (refresh_q == 3'h3 || refresh_q == 3'h5)
      else $error("refresh count not three or five");
   // refresh count moves only after a register write
   rf_write_a: assert property ($changed(refresh_q) |-> $past(data_wr) || $past(data_wr, 2))
      else $error("refresh count moved without a write");
   // extension protect forces group0 protection
   prot_follow_a: assert property (ext_protect |=> g0_protect_q)
      else $error("protection missing with extension bit set");
   // protection never drops while extension bit stays set
   prot_drop_a: assert property ($fell(g0_protect_q) |-> !$past(ext_protect))
      else $error("protection dropped under extension bit");
   // interrupt pends only where display ends on a line edge
   irq_rise_a: assert property ($rose(irq_q) |-> $fell(vdisp_q) && $past(line_tick))
      else $error("interrupt set away from display end");
   // interrupt clears only through a register write
   irq_fall_a: assert property ($fell(irq_q) |-> $past(data_wr) || $past(data_wr, 2))
      else $error("interrupt cleared without a write");
   // vertical levels move only on line edges
   vsync_tick_a: assert property ($changed(vsync_q) |-> $past(line_tick))
      else $error("sync moved between lines");
   vblank_tick_a: assert property ($changed(vblank_q) |-> $past(line_tick))
      else $error("blank moved between lines");
   vdisp_tick_a: assert property ($changed(vdisp_q) |-> $past(line_tick))
      else $error("display enable moved between lines");
   row_tick_a: assert property ($changed(row_scan_q) |-> $past(line_tick))
      else $error("row scan moved between lines");
endmodule // cvc_vert_properties
bind cvc_vert cvc_vert_properties u_props (.sys_clk(sys_clk), .reset(reset),
   .data_wr(data_wr), .line_tick(line_tick), .ext_protect(ext_protect),
   .vsync_q(vsync_q), .vblank_q(vblank_q), .vdisp_q(vdisp_q), .irq_q(irq_q),
   .row_scan_q(row_scan_q), .refresh_q(refresh_q), .g0_protect_q(g0_protect_q));
`default_nettype wire

// file: verif/cvc_crt_monitor.sv
// monitor model: counts lines of each frame from display, sync and blank levels
// assumes line_tick pulses at least two clocks apart
`timescale 1ns/1ps
`default_nettype none
module cvc_crt_monitor (
   input wire logic sys_clk,      // character clock
   input wire logic reset,        // synchronous, active high
   input wire logic line_tick,    // one pulse per line
   input wire logic vsync,        // vertical sync level
   input wire logic vblank,       // vertical blank level
   input wire logic vdisp,        // vertical display level
   output var int   frame_lines,  // lines in last whole frame
   output var int   disp_lines,   // displayed lines in it
   output var int   sync_lines,   // lines with sync active
   output var int   blank_lines   // lines with blank active
);
   int   fl_q, dl_q, sl_q, bl_q;  // running counts of this frame
   logic vd_q;                    // display level one clock back
   // frame starts where display enable rises; latch then restart
   always @(posedge sys_clk) begin
      vd_q <= vdisp;
      if (reset) begin
         {fl_q, dl_q, sl_q, bl_q} <= '0;
         {frame_lines, disp_lines, sync_lines, blank_lines} <= '0;
      end else if (vdisp && !vd_q) begin
         {frame_lines, disp_lines, sync_lines, blank_lines} <= {fl_q, dl_q, sl_q, bl_q};
         {fl_q, dl_q, sl_q, bl_q} <= '0;
      end else if (line_tick) begin
         fl_q <= fl_q + 1;
         dl_q <= dl_q + vdisp;
         sl_q <= sl_q + vsync;
         bl_q <= bl_q + vblank;
      end
   end
endmodule // cvc_crt_monitor
`default_nettype wire

// file: verif/crtc_vertical_cursor_addressing_test.sv
// self-checking bench for the vertical timing block
// assumes cvc_vert, the line monitor and the bound checker
`timescale 1ns/1ps
`default_nettype none
module crtc_vertical_cursor_addressing_test;
   logic        sys_clk = 1'b0, reset = 1'b1;           // clock, reset
   logic        idx_wr = 1'b0, data_wr = 1'b0;          // register strobes
   logic        line_tick = 1'b0, h_disp = 1'b0;        // line timing
   logic        pen_enable = 1'b1, ext_protect = 1'b0;  // read gate, protect
   logic        aux_offset = 1'b0, word_mode_n = 1'b1, count_by_two = 1'b0;
   logic [1:0]  emul_mode = 2'h0;                       // wrap mode
   logic [7:0]  io_wdata = 8'h00, line_cmp_low = 8'hff; // data, split line
   logic [31:0] rng_q = 32'h00010ca1;                   // random state
   logic [7:0]  exp_q [0:31];                           // expected registers
   logic [7:0]  v;                                      // read value
   wire  [7:0]  io_rdata_q;
   wire         vsync_q, vblank_q, vdisp_q, irq_q, cursor_q, underline_q, g0_protect_q;
   wire  [4:0]  row_scan_q;
   wire  [15:0] mem_addr_q;
   wire  [2:0]  refresh_q;
   int          frame_lines, disp_lines, sync_lines, blank_lines;
   int          err_total = 0, checked = 0;
   always #5 sys_clk = ~sys_clk;
   cvc_vert u_dut (.sys_clk(sys_clk), .reset(reset), .idx_wr(idx_wr), .data_wr(data_wr),
      .io_wdata(io_wdata), .line_tick(line_tick), .h_disp(h_disp), .pen_enable(pen_enable),
      .mono_emul(1'b0), .emul_mode(emul_mode), .ext_protect(ext_protect),
      .aux_offset(aux_offset), .word_mode_n(word_mode_n), .count_by_two(count_by_two),
      .line_cmp_low(line_cmp_low), .io_rdata_q(io_rdata_q), .vsync_q(vsync_q),
      .vblank_q(vblank_q), .vdisp_q(vdisp_q), .irq_q(irq_q), .row_scan_q(row_scan_q),
      .mem_addr_q(mem_addr_q), .cursor_q(cursor_q), .underline_q(underline_q),
      .refresh_q(refresh_q), .g0_protect_q(g0_protect_q));
   cvc_crt_monitor u_crt (.sys_clk(sys_clk), .reset(reset), .line_tick(line_tick),
      .vsync(vsync_q), .vblank(vblank_q), .vdisp(vdisp_q), .frame_lines(frame_lines),
      .disp_lines(disp_lines), .sync_lines(sync_lines), .blank_lines(blank_lines));
   // xorshift step of the random state
   function automatic logic [31:0] next_rand();
      rng_q = rng_q ^ (rng_q << 13);
      rng_q = rng_q ^ (rng_q >> 17);
      rng_q = rng_q ^ (rng_q << 5);
      return rng_q;
   endfunction
   // bits that hold data; reserved ones read back zero
   function automatic logic [7:0] reg_mask(input logic [7:0] idx);
      case (idx)
         8'h08, 8'h0b, 8'h14: reg_mask = 8'h7f;
         8'h0a: reg_mask = 8'h3f;
         default: reg_mask = 8'hff;
      endcase
   endfunction
   task automatic step();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // index cycle then data cycle
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      idx_wr = 1'b1;
      io_wdata = idx;
      step();
      idx_wr = 1'b0;
      data_wr = 1'b1;
      io_wdata = d;
      step();
      data_wr = 1'b0;
   endtask
   // index cycle, read data two edges later
   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      idx_wr = 1'b1;
      io_wdata = idx;
      step();
      idx_wr = 1'b0;
      step();
      step();
      d = io_rdata_q;
   endtask
   // lines of four clocks: retrace pulse then active characters
   task automatic ticks(input int n);
      repeat (n) begin
         line_tick = 1'b1;
         step();
         line_tick = 1'b0;
         h_disp = 1'b1;
         step();
         step();
         h_disp = 1'b0;
         step();
      end
   endtask
   // run lines until display enable reaches a level, bounded
   task automatic wait_vdisp(input logic lvl);
      int n;
      for (n = 0; n < 600 && vdisp_q !== lvl; n++) ticks(1);
      if (n == 600) begin
         err_total++;
         close_out();
      end
   endtask
   // program a frame, run it, compare line counts and row scan
   task automatic frame(input logic [9:0] vt, vde, vss, vbs, input logic [7:0] vse, vbe);
      wr(8'h06, vt[7:0]);
      wr(8'h07, {vss[9], vde[9], vt[9], 1'b0, vbs[8], vss[8], vde[8], vt[8]});
      wr(8'h08, 8'h01);
      wr(8'h09, {2'b00, vbs[9], 5'h02});
      wr(8'h10, vss[7:0]);
      wr(8'h11, vse);
      wr(8'h12, vde[7:0]);
      wr(8'h15, vbs[7:0]);
      wr(8'h16, vbe);
      ticks(3 * (vt + 2) + 2);
      check("frame lines", 16'(frame_lines), 16'(vt) + 16'h0002);
      check("disp lines", 16'(disp_lines), 16'(vde) + 16'h0001);
      check("sync lines", 16'(sync_lines), {12'h000, vse[3:0] - vss[3:0]});
      check("blank lines", 16'(blank_lines), {8'h00, vbe - vbs[7:0] + 8'h01});
      wait_vdisp(1'b0);
      wait_vdisp(1'b1);
      check("row preset", {11'h000, row_scan_q}, 16'h0001);
      check("underline", {15'h0, underline_q}, {15'h0, exp_q[20][4:0] == 5'h00});
      ticks(2);
      check("row wrap", {11'h000, row_scan_q}, 16'h0000);
   endtask
   initial begin
      #500000;
      err_total++;
      close_out();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      #1 reset = 1'b0;
      {emul_mode, aux_offset, word_mode_n, count_by_two} = 5'(next_rand());
      // reset values and an unmapped place
      for (int i = 6; i <= 8'h16; i++) begin
         rd(8'(i), v);
         check("reset reg", {8'h00, v}, 16'h0000);
      end
      wr(8'h20, 8'h5a);
      rd(8'h20, v);
      check("unmapped", {8'h00, v}, 16'h0000);
      check("refresh rst", {13'h0000, refresh_q}, 16'h0003);
      check("irq rst", {15'h0000, irq_q}, 16'h0000);
      $display("test reset done");
      // random write then read back of every register
      for (int i = 6; i <= 8'h16; i++) begin
         exp_q[i] = 8'(next_rand()) & reg_mask(8'(i)) & ((i == 8'h11) ? 8'h4f : 8'hff);
         wr(8'(i), exp_q[i]);
      end
      for (int i = 6; i <= 8'h16; i++) begin
         rd(8'(i), v);
         check("reg rw", {8'h00, v}, {8'h00, exp_q[i]});
      end
      $display("test registers done");
      // group0 protection by own bit and extension bit; refresh type
      wr(8'h06, 8'h5a);
      wr(8'h07, 8'h00);
      wr(8'h11, 8'hc0);
      step();
      check("protect", {15'h0000, g0_protect_q}, 16'h0001);
      check("refresh 5", {13'h0000, refresh_q}, 16'h0005);
      wr(8'h06, 8'ha5);
      wr(8'h07, 8'hff);
      rd(8'h06, v);
      check("vt locked", {8'h00, v}, 16'h005a);
      rd(8'h07, v);
      check("lc8 open", {8'h00, v}, 16'h0010);
      wr(8'h11, 8'h00);
      ext_protect = 1'b1;
      step();
      step();
      check("ext protect", {15'h0000, g0_protect_q}, 16'h0001);
      check("refresh 3", {13'h0000, refresh_q}, 16'h0003);
      wr(8'h06, 8'h33);
      rd(8'h06, v);
      check("vt ext lock", {8'h00, v}, 16'h005a);
      ext_protect = 1'b0;
      step();
      $display("test protect done");
      // small frame with interrupt enabled, then clear it with enable left on
      frame(10'h008, 10'h005, 10'h007, 10'h006, 8'h19, 8'h08);
      check("irq pend", {15'h0000, irq_q}, 16'h0001);
      wr(8'h11, 8'h09);
      step();
      step();
      check("irq clear", {15'h0000, irq_q}, 16'h0000);
      // tall frame using bit 8, interrupt disabled
      frame(10'h104, 10'h0f0, 10'h0f8, 10'h0f4, 8'h3a, 8'hfc);
      check("irq off", {15'h0000, irq_q}, 16'h0000);
      $display("test frames done");
      close_out();
   end
endmodule // crtc_vertical_cursor_addressing_test
`default_nettype wire
